// File: rtl/sol_pkg.sv
// Constants, register map and types for the simultaneous output limiter.
package sol_pkg;

    localparam int NCH = 4;
    localparam int PH_W = 24;
    localparam int MV_W = 11;
    localparam int DL_W = 10;
    localparam int PER_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets; per-channel registers step by one word.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MV = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_MVLIM = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_ONTIME = 8'h40;

    // Field positions.
    localparam int CTRL_RESTART = 0;
    localparam int CTRL_SEL_LO = 1;
    localparam int CTRL_FOUR = 3;
    localparam int CTRL_PID = 4;
    localparam int CTRL_HC = 5;
    localparam int CTRL_EN_LO = 8;
    localparam int LIM_LOWER_LO = 16;
    localparam int STAT_ACTIVE = 4;

    // Limit selection encoding.
    typedef enum logic [1:0] {
        SOL_UNRES = 2'h0,
        SOL_THREE = 2'h1,
        SOL_TWO = 2'h2,
        SOL_ONE = 2'h3
    } sol_limit_t;

    // Reset values and the delay maximum.
    localparam logic [DL_W-1:0] DELAY_RST = 10'h00A;
    localparam logic [DL_W-1:0] DELAY_MAX = 10'h3E8;
    localparam logic [MV_W-1:0] MV_FULL = 11'h3E8;
    localparam logic [PER_W-1:0] PERIOD_RST = 16'h07D0;
    localparam logic FOUR_RST = 1'h1;
    localparam logic PID_RST = 1'h1;
    localparam logic HC_RST = 1'h0;
    localparam logic [NCH-1:0] EN_RST = 4'hF;

    // Timing: one millisecond in reference clock cycles.
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

endpackage

// File: rtl/sol_limiter.sv
// Simultaneous output limiter: staggered, clamped time-proportional outputs.
// Notes on behaviour
// (RULE1) Limit active: stagger channels by half or quarter.
// (RULE2) Four channels: ceiling 75, 50, 25 percent.
// (RULE3) Two channels: only single-output limit clamps, 50%.
// (RULE4) Nonzero delay lowers ceiling by one delay.
// (RULE5) Limit active: channel one period drives all.
// (RULE6) Output bounded by smaller of upper and ceiling.
// (RULE7) Lower limit above ceiling: hold at ceiling.
// (RULE8) Delay inserts forced off gap between slots.
// (RULE9) Actual period adds one delay per slot.
// (RULE10) Disabled channel always outputs zero.
// (RULE11) Selection codes 0..3, default unrestricted.
// (RULE12) Delay 0 to 1000 ms, default 10.
// (RULE13) Only under PID, never for heating/cooling.
// (RULE14) ON time is clamped share from slot start.
// (RULE15) Settings take effect only at reset or restart; the upper and lower MV limits apply at once.
module sol_limiter #(
    parameter int MS_CYCLES_P = sol_pkg::MS_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [sol_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sol_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [sol_pkg::DATA_W-1:0] regRdData,
    // Control outputs to the actuators.
    output logic [sol_pkg::NCH-1:0] ctrlOut,
    output logic limitActive
);
    import sol_pkg::*;

    // Share of a period in ms for a value in tenths of a percent.
    function automatic logic [PH_W-1:0] solShare(input logic [MV_W-1:0] mv,
                                                input logic [PH_W-1:0] act);
        logic [34:0] prod;
        prod = 35'(mv) * 35'(act);
        return PH_W'(prod / 35'(MV_FULL));
    endfunction

    function automatic logic [MV_W-1:0] solClipMv(input logic [MV_W-1:0] mv);
        return (mv > MV_FULL) ? MV_FULL : mv;
    endfunction

    // Live settings written by software.
    sol_limit_t sel_q;
    logic four_q;
    logic pid_q;
    logic hc_q;
    logic [NCH-1:0] en_q;
    logic [DL_W-1:0] delay_q;
    logic [PER_W-1:0] period_q [NCH];
    logic [MV_W-1:0] mv_q [NCH];
    logic [MV_W-1:0] upper_q [NCH];
    logic [MV_W-1:0] lower_q [NCH];

    // Settings in force, taken at reset or restart.
    sol_limit_t selS_q;
    logic fourS_q;
    logic pidS_q;
    logic hcS_q;
    logic [NCH-1:0] enS_q;
    logic [DL_W-1:0] delayS_q;
    logic [PER_W-1:0] periodS_q [NCH];

    // Restart is a one-cycle pulse; the settings in force follow it one cycle later.
    logic restart_q;
    logic [31:0] msCnt_q;
    logic [PH_W-1:0] phase_q [NCH];
    logic [NCH-1:0] ctrlOut_q;
    logic limitActive_q;
    logic [DATA_W-1:0] rdData_q;

    // Register decode.
    wire logic [1:0] chIdx = regAddr[3:2];
    wire logic [3:0] grp = regAddr[7:4];
    wire logic wrCtrl = regWrEn && (regAddr == OFS_CTRL);
    wire logic wrDelay = regWrEn && (regAddr == OFS_DELAY);
    wire logic wrPeriod = regWrEn && (grp == OFS_PERIOD[7:4]);
    wire logic wrMv = regWrEn && (grp == OFS_MV[7:4]);
    wire logic wrLim = regWrEn && (grp == OFS_MVLIM[7:4]);
    wire logic [MV_W-1:0] wrMvVal = solClipMv(regWrData[MV_W-1:0]);
    wire logic [MV_W-1:0] wrUpVal = solClipMv(regWrData[MV_W-1:0]);
    wire logic [MV_W-1:0] wrLoVal = solClipMv(regWrData[LIM_LOWER_LO +: MV_W]);
    // Out-of-range values are clipped, so software always reads back a legal value.
    wire logic [DL_W-1:0] wrDlVal = (regWrData[15:0] > 16'(DELAY_MAX)) ?
                                    DELAY_MAX : regWrData[DL_W-1:0]; // RULE12

    // Limit in force and slot geometry.
    // A two-channel unit treats the three- and two-output limits as no limit.
    wire logic limActW = pidS_q && !hcS_q &&
                         ((selS_q == SOL_ONE) ||
                          (fourS_q && (selS_q != SOL_UNRES))); // RULE3 RULE13 RULE11
    wire logic [PH_W-1:0] delayX = PH_W'(delayS_q);
    wire logic [PH_W-1:0] slotsW = fourS_q ? 24'h000004 : 24'h000002;
    // The actual period grows by one delay for every output slot.
    wire logic [PH_W-1:0] actLead = PH_W'(periodS_q[0]) +
                                    PH_W'(slotsW * delayX); // RULE9
    wire logic [PH_W-1:0] slotLen = fourS_q ? (actLead >> 2) : (actLead >> 1);
    wire logic [PH_W-1:0] allowW = fourS_q ? PH_W'(3'h4 - 3'(selS_q)) : 24'h000001; // RULE2
    // The ceiling is in ms of on time; a delay as long as the allowed slots leaves none.
    wire logic [PH_W-1:0] capRaw = PH_W'(allowW * slotLen);
    wire logic [PH_W-1:0] capW = (capRaw > delayX) ? capRaw - delayX : 24'h000000; // RULE4 RULE8
    wire logic msTick = (msCnt_q == 32'(MS_CYCLES_P - 1));

    // Per-channel timing, all counted in ms ticks.
    logic [PH_W-1:0] actK [NCH];
    logic [PH_W-1:0] offK [NCH];
    logic [PH_W-1:0] reqT [NCH];
    logic [PH_W-1:0] onT [NCH];
    logic [PH_W-1:0] relT [NCH];
    logic [MV_W-1:0] mvLo [NCH];
    logic [MV_W-1:0] mvLim [NCH];
    logic [NCH-1:0] outD;

    for (genvar k = 0; k < NCH; k++) begin : g_ch
        assign actK[k] = limActW ? actLead : PH_W'(periodS_q[k]); // RULE5
        assign offK[k] = limActW ? PH_W'(PH_W'(k) * slotLen) : 24'h000000; // RULE1
        // An upper limit set below the lower limit wins over it.
        assign mvLo[k] = (mv_q[k] < lower_q[k]) ? lower_q[k] : mv_q[k];
        assign mvLim[k] = (mvLo[k] > upper_q[k]) ? upper_q[k] : mvLo[k]; // RULE6
        assign reqT[k] = solShare(mvLim[k], actK[k]);
        assign onT[k] = !enS_q[k] ? 24'h000000 : // RULE10
                        ((limActW && (reqT[k] > capW)) ? capW : reqT[k]); // RULE6 RULE7
        // Time since this channel's slot start, wrapped at the end of the period.
        assign relT[k] = (phase_q[k] >= offK[k]) ? phase_q[k] - offK[k] :
                         phase_q[k] + actK[k] - offK[k];
        assign outD[k] = (relT[k] < onT[k]); // RULE14
    end

    // Register writes.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= SOL_UNRES;
            four_q <= FOUR_RST;
            pid_q <= PID_RST;
            hc_q <= HC_RST;
            en_q <= EN_RST;
            delay_q <= DELAY_RST;
            restart_q <= 1'h0;
        end else begin
            // The restart bit is not stored; it only raises the one-cycle pulse.
            restart_q <= wrCtrl && regWrData[CTRL_RESTART];
            if (wrCtrl) begin
                sel_q <= sol_limit_t'(regWrData[CTRL_SEL_LO +: 2]);
                four_q <= regWrData[CTRL_FOUR];
                pid_q <= regWrData[CTRL_PID];
                hc_q <= regWrData[CTRL_HC];
                en_q <= regWrData[CTRL_EN_LO +: NCH];
            end
            if (wrDelay) begin
                delay_q <= wrDlVal;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                period_q[i] <= PERIOD_RST;
                mv_q[i] <= 11'h000;
                upper_q[i] <= MV_FULL;
                lower_q[i] <= 11'h000;
            end
        end else begin
            if (wrPeriod) begin
                period_q[chIdx] <= regWrData[PER_W-1:0];
            end
            if (wrMv) begin
                mv_q[chIdx] <= wrMvVal;
            end
            if (wrLim) begin
                upper_q[chIdx] <= wrUpVal;
                lower_q[chIdx] <= wrLoVal;
            end
        end
    end

    // Settings in force change only on restart.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            selS_q <= SOL_UNRES;
            fourS_q <= FOUR_RST;
            pidS_q <= PID_RST;
            hcS_q <= HC_RST;
            enS_q <= EN_RST;
            delayS_q <= DELAY_RST;
            for (int i = 0; i < NCH; i++) begin
                periodS_q[i] <= PERIOD_RST;
            end
        end else if (restart_q) begin // RULE15
            selS_q <= sel_q;
            fourS_q <= four_q;
            pidS_q <= pid_q;
            hcS_q <= hc_q;
            enS_q <= en_q;
            delayS_q <= delay_q;
            periodS_q <= period_q;
        end
    end

    // Millisecond timebase and period phases; all restart together so slots stay aligned.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            msCnt_q <= 32'h00000000;
            for (int i = 0; i < NCH; i++) begin
                phase_q[i] <= 24'h000000;
            end
        end else begin
            msCnt_q <= (restart_q || msTick) ? 32'h00000000 : msCnt_q + 32'h00000001;
            for (int i = 0; i < NCH; i++) begin
                if (restart_q || (msTick && (phase_q[i] + 24'h000001 >= actK[i]))) begin
                    phase_q[i] <= 24'h000000;
                end else if (msTick) begin
                    phase_q[i] <= phase_q[i] + 24'h000001;
                end
            end
        end
    end

    // Read data selection.
    wire logic [DATA_W-1:0] ctrlRd = {20'h00000, en_q, 2'h0, hc_q, pid_q, four_q, sel_q, 1'h0};
    wire logic [DATA_W-1:0] statRd = {27'h0000000, limitActive_q, ctrlOut_q};
    wire logic [DATA_W-1:0] limRd = {5'h00, lower_q[chIdx], 5'h00, upper_q[chIdx]};
    wire logic [DATA_W-1:0] rdSel =
        (regAddr == OFS_CTRL) ? ctrlRd :
        (regAddr == OFS_DELAY) ? DATA_W'(delay_q) :
        (regAddr == OFS_STAT) ? statRd :
        (grp == OFS_PERIOD[7:4]) ? DATA_W'(period_q[chIdx]) :
        (grp == OFS_MV[7:4]) ? DATA_W'(mv_q[chIdx]) :
        (grp == OFS_MVLIM[7:4]) ? limRd :
        (grp == OFS_ONTIME[7:4]) ? DATA_W'(onT[chIdx]) : 32'h00000000;

    // Read data stand for one cycle only and read zero otherwise.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 32'h00000000;
            ctrlOut_q <= 4'h0;
            limitActive_q <= 1'h0;
        end else begin
            rdData_q <= regRdEn ? rdSel : 32'h00000000;
            ctrlOut_q <= outD;
            limitActive_q <= limActW;
        end
    end

    assign regRdData = rdData_q;
    assign ctrlOut = ctrlOut_q;
    assign limitActive = limitActive_q;

    // Checks on the limiter's own behaviour.
    a_disabled_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE10
        !enS_q[0] |=> !ctrlOut[0]) else $error("disabled channel drove output");

    a_cap_bound: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        limActW |-> (onT[2] <= capW) && (onT[2] <= solShare(upper_q[2], actK[2])))
        else $error("on time above ceiling or upper limit");

    a_lower_fix: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
        limActW && enS_q[0] && (upper_q[0] >= lower_q[0]) &&
            (solShare(lower_q[0], actK[0]) >= capW) |-> onT[0] == capW)
        else $error("lower limit above ceiling not held at ceiling");

    a_two_free: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        !fourS_q && (selS_q != SOL_ONE) |-> !limActW)
        else $error("two channel unit limited");

    a_lead_period: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        limActW |-> (actK[3] == actK[0]) && (actK[1] == actLead))
        else $error("channel period not taken from lead channel");

    a_actual_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
        limActW && fourS_q |-> actK[0] == PH_W'(periodS_q[0]) + 4 * delayX)
        else $error("actual period length wrong");

    a_stagger_quarter: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        limActW && fourS_q |-> offK[2] == (actLead >> 2) * 2)
        else $error("quarter stagger wrong");

    a_hc_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
        hcS_q || !pidS_q |=> !limitActive)
        else $error("limit active outside plain PID");

    a_restart_only: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
        !restart_q |=> $stable(selS_q) && $stable(delayS_q))
        else $error("settings changed without restart");

    a_single_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        $past(limActW && (selS_q == SOL_ONE)) |-> $onehot0(ctrlOut))
        else $error("two outputs on under single output limit");

    a_delay_range: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        wrDelay |=> delay_q <= DELAY_MAX)
        else $error("delay above range");

    a_stagger_half: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        limActW && !fourS_q |-> offK[1] == (actLead >> 1))
        else $error("half stagger wrong");

    a_off_gap: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        limActW && (selS_q == SOL_ONE) |->
            (onT[1] == 24'h000000) || (onT[1] + delayX <= slotLen))
        else $error("no off gap before next slot");

    a_delay_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        !limActW |-> (actK[0] == PH_W'(periodS_q[0])) && (offK[3] == 24'h000000))
        else $error("delay or stagger applied without a limit");

    a_four_ceiling: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        limActW && fourS_q && (delayS_q == 10'h000) |->
            capW == ((selS_q == SOL_THREE) ? 3 * slotLen :
                     (selS_q == SOL_TWO) ? 2 * slotLen : slotLen))
        else $error("four channel ceiling wrong");

    a_two_single: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        limActW && !fourS_q && (delayS_q == 10'h000) |-> capW == (actLead >> 1))
        else $error("two channel ceiling wrong");

    a_read_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !regRdEn |=> regRdData == 32'h00000000)
        else $error("read data outside read cycle");

    a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
        (actK[2] != 24'h000000) |-> phase_q[2] < actK[2])
        else $error("phase beyond period");

    // Main scenarios worth seeing in simulation.
    c_four_single: cover property (@(posedge ref_clk) disable iff (!rst_n)
        limitActive && fourS_q && (selS_q == SOL_ONE) && ctrlOut[3]);
    c_two_single: cover property (@(posedge ref_clk) disable iff (!rst_n)
        limitActive && !fourS_q && ctrlOut[1]);
    c_capped: cover property (@(posedge ref_clk) disable iff (!rst_n)
        limActW && (delayS_q != 10'h000) && (reqT[0] > capW));
    c_off_gap: cover property (@(posedge ref_clk) disable iff (!rst_n)
        limitActive && (delayS_q != 10'h000) && $fell(ctrlOut[0]));
    c_lead_disabled: cover property (@(posedge ref_clk) disable iff (!rst_n)
        limitActive && !enS_q[0] && ctrlOut[1]);

endmodule // sol_limiter

// File: tb/sol_actuator_model.sv
// Actuator model: counts ON samples, overlap and last turn-on time of each output.
module sol_actuator_model (
    // Clock.
    input wire logic ref_clk,
    // Control outputs and measuring window.
    input wire logic [sol_pkg::NCH-1:0] ctrlOut,
    input wire logic run
);
    timeunit 1ns;
    timeprecision 1ps;
    import sol_pkg::*;
    int onCnt[NCH];
    int riseAt[NCH];
    int maxOn = 0;
    int now = 0;
    logic [NCH-1:0] prevOut = '0;

    initial begin
        foreach (onCnt[k]) begin
            onCnt[k] = 0;
            riseAt[k] = 0;
        end
    end

    // Sampling on the falling edge keeps clear of the output register's update.
    always @(negedge ref_clk) begin
        int n;
        n = 0;
        now++;
        if (run) begin
            for (int k = 0; k < NCH; k++) begin
                if (ctrlOut[k] === 1'b1) begin
                    onCnt[k]++;
                    n++;
                    if (prevOut[k] !== 1'b1) begin
                        riseAt[k] = now;
                    end
                end
            end
            if (n > maxOn) begin
                maxOn = n;
            end
        end
        prevOut = ctrlOut;
    end
endmodule // sol_actuator_model

// File: tb/sol_limiter_test.sv
// Self-checking testbench for the simultaneous output limiter.
module sol_limiter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sol_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic [NCH-1:0] ctrlOut;
    logic limitActive;
    logic run = 1'b0;
    logic [31:0] d;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int num;

    // One tick per clock keeps every period short in cycles.
    sol_limiter #(.MS_CYCLES_P(1)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .ctrlOut(ctrlOut), .limitActive(limitActive));
    sol_actuator_model load (.ref_clk(ref_clk), .ctrlOut(ctrlOut), .run(run));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
        v = regRdData;
    endtask

    task automatic cfg(input logic [3:0] en, input logic hc, input logic pid, input logic four,
            input logic [1:0] sel, input logic [9:0] dly, input logic [15:0] per);
        wr(OFS_DELAY, {22'h000000, dly});
        wr(OFS_PERIOD, {16'h0000, per});
        wr(OFS_CTRL, {20'h00000, en, 2'h0, hc, pid, four, sel, 1'b1});
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic chkOn(input int ch, input logic [31:0] exp);
        rd(OFS_ONTIME + 8'(4 * ch), d);
        chk("ontime", exp, d);
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, d);
        chk("ctrl reset", 32'h00000F18, d);
        rd(OFS_DELAY, d);
        chk("delay reset", 32'h0000000A, d);
        rd(OFS_PERIOD, d);
        chk("period reset", 32'h000007D0, d);
        rd(OFS_MVLIM, d);
        chk("mvlim reset", 32'h000003E8, d);
        rd(8'hFC, d);
        chk("unmapped", 32'h00000000, d);
        $display("Test reset values done");
        wr(OFS_MV, 32'h000003E8);
        for (int f = 1; f >= 0; f--) begin
            for (int s = 0; s < 4; s++) begin
                cfg(4'hF, 1'b0, 1'b1, f[0], s[1:0], 10'h000, 16'h03E8);
                num = f ? (s == 0 ? 1000 : (4 - s) * 250) : (s == 3 ? 500 : 1000);
                chkOn(0, num);
                rd(OFS_STAT, d);
                chk("active", f ? 32'(s != 0) : 32'(s == 3), 32'(d[STAT_ACTIVE]));
            end
        end
        $display("Test selection table done");
        wr(OFS_MV + 8'h04, 32'h000001F4);
        cfg(4'hF, 1'b0, 1'b1, 1'b1, SOL_THREE, 10'h3E8, 16'h2710);
        chkOn(0, 9500);
        chkOn(1, 7000);
        cfg(4'hF, 1'b0, 1'b1, 1'b0, SOL_ONE, 10'h3E8, 16'h2710);
        chkOn(0, 5000);
        cfg(4'hF, 1'b0, 1'b1, 1'b1, SOL_UNRES, 10'h3E8, 16'h03E8);
        chkOn(0, 1000);
        wr(OFS_DELAY, 32'h000007D0);
        rd(OFS_DELAY, d);
        chk("delay clip", 32'h000003E8, d);
        $display("Test delay done");
        wr(OFS_PERIOD + 8'h04, 32'h000001F4);
        wr(OFS_MV + 8'h04, 32'h000000C8);
        chkOn(1, 400);
        cfg(4'hE, 1'b0, 1'b1, 1'b1, SOL_ONE, 10'h000, 16'h03E8);
        chkOn(1, 200);
        chkOn(0, 0);
        $display("Test lead period and disable done");
        cfg(4'hF, 1'b0, 1'b1, 1'b1, SOL_ONE, 10'h000, 16'h03E8);
        wr(OFS_MVLIM, 32'h000000C8);
        chkOn(0, 200);
        wr(OFS_MVLIM, 32'h012C03E8);
        wr(OFS_MV, 32'h00000000);
        chkOn(0, 250);
        wr(OFS_MVLIM, 32'h000003E8);
        wr(OFS_MV, 32'h000003E8);
        chkOn(0, 250);
        wr(OFS_CTRL, 32'h00000F18);
        repeat (3) @(posedge ref_clk);
        chkOn(0, 250);
        chk("active held", 32'h00000001, 32'(limitActive));
        $display("Test clamps and latching done");
        cfg(4'hF, 1'b0, 1'b0, 1'b1, SOL_ONE, 10'h000, 16'h03E8);
        chkOn(0, 1000);
        chk("active pid off", 32'h00000000, 32'(limitActive));
        cfg(4'hF, 1'b1, 1'b1, 1'b1, SOL_ONE, 10'h000, 16'h03E8);
        chkOn(0, 1000);
        $display("Test mode gating done");
        for (int k = 1; k < NCH; k++) begin
            wr(OFS_MV + 8'(4 * k), 32'h000003E8);
        end
        cfg(4'hF, 1'b0, 1'b1, 1'b1, SOL_ONE, 10'h002, 16'h0028);
        chkOn(3, 10);
        repeat (10) @(posedge ref_clk);
        run <= 1'b1;
        repeat (96) @(posedge ref_clk);
        run <= 1'b0;
        @(posedge ref_clk);
        chk("overlap", 32'h00000001, 32'(load.maxOn));
        for (int k = 0; k < NCH; k++) begin
            chk("on count", 32'h00000014, 32'(load.onCnt[k]));
            num = ((load.riseAt[k] - load.riseAt[0]) % 48 + 48) % 48;
            chk("offset", 32'(12 * k), 32'(num));
        end
        $display("Test staggered outputs done");
        wrap_up();
    end
endmodule // sol_limiter_test
